// [include/bsm_pkg.sv]
// Behaviour
// - Flag event when pin exceeds selected threshold
// - Any event drives active-low interrupt pin
// - Readable status shows which pin tripped
// - Monitoring disabled after reset
// - Channel one power-down bit, reset one
// - Channel one threshold select, reset 525 mV
// - Channel two power-down bit, reset one
// - Channel two threshold select, same coding
`default_nettype none

package bsm_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] SUB_MAPSEL = 8'h0E;
    localparam logic [7:0] SUB_CH_ONE = 8'h5D;
    localparam logic [7:0] SUB_CH_TWO = 8'h5E;
    localparam logic [7:0] SUB_STATUS = 8'h5F;
    localparam int MAPSEL_LSB = 5;
    localparam int PD_BIT = 6;
    localparam int SEL_LSB = 2;
    localparam logic [1:0] USER_SUBMAP = 2'h0;
    localparam logic [1:0] MAPSEL_RESET = 2'h0;
    localparam logic PD_RESET = 1'h1;
    localparam logic [2:0] SEL_RESET = 3'h3;

    // ----------------------------------------------------------------
    // Serial port and thresholds
    // ----------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR_BASE = 7'h20;
    localparam int ADDR_SEL_BIT = 1;
    localparam int THR_BASE_MV = 75;
    localparam int THR_STEP_MV = 150;
    localparam int SENSE_W_MIN = 11;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
        ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
    } bsm_state_t;

endpackage

`default_nettype wire

// [src/bsm_channel.sv]
`default_nettype none

module bsm_channel #(
    parameter int SENSE_W = 11
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [SENSE_W-1:0] sense_mv,
    input wire logic power_down,
    input wire logic [2:0] threshold_sel,
    input wire logic clear,
    output logic battery_short_event
);

    typedef struct packed {
        logic flag;
    } bsm_chan_t;

    bsm_chan_t cur;
    bsm_chan_t nx;
    logic [SENSE_W-1:0] thr;
    logic hit;

    if (SENSE_W < bsm_pkg::SENSE_W_MIN)
    begin : g_bad_width
        $error("sense width too narrow for 1125 mV");
    end

    // ----------------------------------------------------------------
    // Comparator and latch
    // ----------------------------------------------------------------
    always_comb
    begin
        thr = SENSE_W'(bsm_pkg::THR_BASE_MV) + SENSE_W'(bsm_pkg::THR_STEP_MV) * SENSE_W'(threshold_sel);
        hit = !power_down && (sense_mv > thr);
        nx = cur;
        // Set beats clear so an event during a status read is kept
        nx.flag = (cur.flag && !clear) || hit;
        if (power_down)
        begin
            nx.flag = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= nx;
        end
    end

    assign battery_short_event = cur.flag;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_hit_latches: assert property (@(posedge clock) disable iff (!nrst)
        hit |=> battery_short_event)
        else $error("threshold crossing not latched");
    a_pd_silent: assert property (@(posedge clock) disable iff (!nrst)
        power_down |=> !battery_short_event)
        else $error("powered-down channel flagged");
    a_flag_holds: assert property (@(posedge clock) disable iff (!nrst)
        battery_short_event && !clear && !power_down |=> battery_short_event)
        else $error("event dropped without clear");

endmodule

`default_nettype wire

// [src/bsm_monitor.sv]
`default_nettype none

module bsm_monitor #(
    parameter int SENSE_W = 11
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic alsb,
    input wire logic [SENSE_W-1:0] short_sense_pin_one,
    input wire logic [SENSE_W-1:0] short_sense_pin_two,
    output logic interrupt_request_n
);

    typedef struct packed {
        logic [1:0] scl_q;
        logic scl_d;
        logic [1:0] sda_q;
        logic sda_d;
        logic [1:0] alsb_q;
        bsm_pkg::bsm_state_t st;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic rw;
        logic acked;
        logic [7:0] sub;
        logic sda_oe;
        logic sda_out;
        logic [1:0] submap_select;
        logic sense_one_power_down;
        logic [2:0] sense_one_threshold_sel;
        logic sense_two_power_down;
        logic [2:0] sense_two_threshold_sel;
        logic irq_n;
    } bsm_mon_t;

    bsm_mon_t cur;
    bsm_mon_t nx;
    logic [1:0] flags;
    logic [1:0] ch_clear;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic wr_en;
    logic status_load;
    logic user_map;
    logic [6:0] my_addr;
    logic [1:0] ch_power_down;
    logic [1:0][2:0] ch_threshold_sel;
    logic [1:0][SENSE_W-1:0] ch_sense;

    localparam int MSB_MAP = bsm_pkg::MAPSEL_LSB + 1;
    localparam int MSB_SEL = bsm_pkg::SEL_LSB + 2;

    // ----------------------------------------------------------------
    // Bus line conditions, second synchroniser stage compared with its one-cycle delayed copy
    // ----------------------------------------------------------------
    assign scl_rise = cur.scl_q[1] && !cur.scl_d;
    assign scl_fall = !cur.scl_q[1] && cur.scl_d;
    assign start_seen = cur.scl_q[1] && cur.scl_d && !cur.sda_q[1] && cur.sda_d;
    assign stop_seen = cur.scl_q[1] && cur.scl_d && cur.sda_q[1] && !cur.sda_d;
    assign user_map = cur.submap_select == bsm_pkg::USER_SUBMAP;

    always_comb
    begin
        my_addr = bsm_pkg::DEV_ADDR_BASE;
        my_addr[bsm_pkg::ADDR_SEL_BIT] = cur.alsb_q[1];
    end

    // ----------------------------------------------------------------
    // Serial port and register file
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [7:0] load_sub;
        logic [7:0] rd_data;
        logic load;
        load_sub = cur.sub;
        rd_data = 8'h00;
        load = 1'b0;
        nx = cur;
        wr_en = 1'b0;
        status_load = 1'b0;
        ch_clear = 2'b00;
        nx.scl_q = {cur.scl_q[0], scl};
        nx.scl_d = cur.scl_q[1];
        nx.sda_q = {cur.sda_q[0], sda_in};
        nx.sda_d = cur.sda_q[1];
        nx.alsb_q = {cur.alsb_q[0], alsb};
        nx.sda_out = 1'b0;
        nx.irq_n = ~|flags;

        if (start_seen)
        begin
            nx.st = bsm_pkg::ST_ADDR;
            nx.cnt = 4'h0;
            nx.sda_oe = 1'b0;
        end
        else if (stop_seen)
        begin
            nx.st = bsm_pkg::ST_IDLE;
            nx.sda_oe = 1'b0;
        end
        else if (scl_rise)
        begin
            case (cur.st)
                bsm_pkg::ST_ADDR, bsm_pkg::ST_SUB, bsm_pkg::ST_WDATA:
                begin
                    if (cur.cnt < 4'h8)
                    begin
                        nx.shreg = {cur.shreg[6:0], cur.sda_q[1]};
                        nx.cnt = cur.cnt + 4'h1;
                    end
                end
                bsm_pkg::ST_RACK: nx.acked = !cur.sda_q[1];
                default: ;
            endcase
        end
        else if (scl_fall)
        begin
            case (cur.st)
                bsm_pkg::ST_ADDR:
                begin
                    if (cur.cnt == 4'h8)
                    begin
                        if (cur.shreg[7:1] == my_addr)
                        begin
                            nx.sda_oe = 1'b1;
                            nx.rw = cur.shreg[0];
                            nx.st = bsm_pkg::ST_ADDR_ACK;
                        end
                        else
                        begin
                            nx.st = bsm_pkg::ST_IDLE;
                        end
                    end
                end
                bsm_pkg::ST_ADDR_ACK:
                begin
                    nx.sda_oe = 1'b0;
                    nx.cnt = 4'h0;
                    nx.st = bsm_pkg::ST_SUB;
                    load = cur.rw;
                end
                bsm_pkg::ST_SUB:
                begin
                    if (cur.cnt == 4'h8)
                    begin
                        // The monitor registers only answer inside the user sub map
                        if (cur.shreg == bsm_pkg::SUB_MAPSEL ||
                            (user_map && (cur.shreg == bsm_pkg::SUB_CH_ONE || cur.shreg == bsm_pkg::SUB_CH_TWO ||
                                          cur.shreg == bsm_pkg::SUB_STATUS)))
                        begin
                            nx.sda_oe = 1'b1;
                            nx.sub = cur.shreg;
                            nx.st = bsm_pkg::ST_SUB_ACK;
                        end
                        else
                        begin
                            nx.st = bsm_pkg::ST_IDLE;
                        end
                    end
                end
                bsm_pkg::ST_SUB_ACK:
                begin
                    nx.sda_oe = 1'b0;
                    nx.cnt = 4'h0;
                    nx.st = bsm_pkg::ST_WDATA;
                end
                bsm_pkg::ST_WDATA:
                begin
                    if (cur.cnt == 4'h8)
                    begin
                        if (cur.sub == bsm_pkg::SUB_MAPSEL ||
                            (user_map && (cur.sub == bsm_pkg::SUB_CH_ONE || cur.sub == bsm_pkg::SUB_CH_TWO)))
                        begin
                            wr_en = 1'b1;
                            nx.sda_oe = 1'b1;
                            nx.st = bsm_pkg::ST_WACK;
                        end
                        else
                        begin
                            nx.st = bsm_pkg::ST_IDLE;
                        end
                    end
                end
                bsm_pkg::ST_WACK:
                begin
                    nx.sda_oe = 1'b0;
                    nx.cnt = 4'h0;
                    nx.sub = cur.sub + 8'h01;
                    nx.st = bsm_pkg::ST_WDATA;
                end
                bsm_pkg::ST_RDATA:
                begin
                    if (cur.cnt == 4'h7)
                    begin
                        nx.sda_oe = 1'b0;
                        nx.st = bsm_pkg::ST_RACK;
                    end
                    else
                    begin
                        nx.shreg = {cur.shreg[6:0], 1'b0};
                        nx.cnt = cur.cnt + 4'h1;
                        nx.sda_oe = !cur.shreg[6];
                    end
                end
                bsm_pkg::ST_RACK:
                begin
                    if (cur.acked)
                    begin
                        load_sub = cur.sub + 8'h01;
                        nx.sub = load_sub;
                        load = 1'b1;
                    end
                    else
                    begin
                        nx.st = bsm_pkg::ST_IDLE;
                    end
                end
                default: nx.st = bsm_pkg::ST_IDLE;
            endcase
        end

        case (load_sub)
            bsm_pkg::SUB_MAPSEL: rd_data[MSB_MAP:bsm_pkg::MAPSEL_LSB] = cur.submap_select;
            bsm_pkg::SUB_CH_ONE:
            begin
                rd_data[bsm_pkg::PD_BIT] = cur.sense_one_power_down;
                rd_data[MSB_SEL:bsm_pkg::SEL_LSB] = cur.sense_one_threshold_sel;
            end
            bsm_pkg::SUB_CH_TWO:
            begin
                rd_data[bsm_pkg::PD_BIT] = cur.sense_two_power_down;
                rd_data[MSB_SEL:bsm_pkg::SEL_LSB] = cur.sense_two_threshold_sel;
            end
            bsm_pkg::SUB_STATUS: rd_data[1:0] = flags;
            default: rd_data = 8'h00;
        endcase

        if (load)
        begin
            nx.shreg = rd_data;
            nx.sda_oe = !rd_data[7];
            nx.cnt = 4'h0;
            nx.st = bsm_pkg::ST_RDATA;
            // Reading the status clears it; the channel lets a new hit win
            status_load = (load_sub == bsm_pkg::SUB_STATUS) && user_map;
            ch_clear = status_load ? 2'b11 : 2'b00;
        end

        if (wr_en)
        begin
            case (cur.sub)
                bsm_pkg::SUB_MAPSEL: nx.submap_select = cur.shreg[MSB_MAP:bsm_pkg::MAPSEL_LSB];
                bsm_pkg::SUB_CH_ONE:
                begin
                    nx.sense_one_power_down = cur.shreg[bsm_pkg::PD_BIT];
                    nx.sense_one_threshold_sel = cur.shreg[MSB_SEL:bsm_pkg::SEL_LSB];
                end
                bsm_pkg::SUB_CH_TWO:
                begin
                    nx.sense_two_power_down = cur.shreg[bsm_pkg::PD_BIT];
                    nx.sense_two_threshold_sel = cur.shreg[MSB_SEL:bsm_pkg::SEL_LSB];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            cur <= '0;
            cur.scl_q <= 2'h3;
            cur.scl_d <= 1'b1;
            cur.sda_q <= 2'h3;
            cur.sda_d <= 1'b1;
            cur.st <= bsm_pkg::ST_IDLE;
            cur.submap_select <= bsm_pkg::MAPSEL_RESET;
            cur.sense_one_power_down <= bsm_pkg::PD_RESET;
            cur.sense_one_threshold_sel <= bsm_pkg::SEL_RESET;
            cur.sense_two_power_down <= bsm_pkg::PD_RESET;
            cur.sense_two_threshold_sel <= bsm_pkg::SEL_RESET;
            cur.irq_n <= 1'b1;
        end
        else
        begin
            cur <= nx;
        end
    end

    // ----------------------------------------------------------------
    // Sense channels
    // ----------------------------------------------------------------
    assign ch_power_down = {cur.sense_two_power_down, cur.sense_one_power_down};
    assign ch_threshold_sel = {cur.sense_two_threshold_sel, cur.sense_one_threshold_sel};
    assign ch_sense = {short_sense_pin_two, short_sense_pin_one};

    for (genvar i = 0; i < 2; i++)
    begin : g_chan
        bsm_channel #(.SENSE_W(SENSE_W)) bsm_channel_inst (
            .clock(clock),
            .nrst(nrst),
            .sense_mv(ch_sense[i]),
            .power_down(ch_power_down[i]),
            .threshold_sel(ch_threshold_sel[i]),
            .clear(ch_clear[i]),
            .battery_short_event(flags[i])
        );
    end

    assign sda_out = cur.sda_out;
    assign sda_oe = cur.sda_oe;
    assign interrupt_request_n = cur.irq_n;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_both_down;
        cur.sense_one_power_down && cur.sense_two_power_down ##1
        cur.sense_one_power_down && cur.sense_two_power_down;
    endsequence

    sequence s_ch_one_write;
        wr_en && cur.sub == bsm_pkg::SUB_CH_ONE;
    endsequence

    sequence s_ch_two_write;
        wr_en && cur.sub == bsm_pkg::SUB_CH_TWO;
    endsequence

    a_irq_raise: assert property (@(posedge clock) disable iff (!nrst)
        flags != 2'b00 |=> !interrupt_request_n)
        else $error("interrupt not raised on event");
    a_irq_quiet: assert property (@(posedge clock) disable iff (!nrst)
        flags == 2'b00 |=> interrupt_request_n)
        else $error("interrupt without event");
    a_status_view: assert property (@(posedge clock) disable iff (!nrst)
        status_load |=> cur.shreg[1:0] == $past(flags) && cur.shreg[7:2] == 6'h00)
        else $error("status byte does not show tripped pins");
    a_reset_off: assert property (@(posedge clock)
        $rose(nrst) |-> cur.sense_one_power_down && cur.sense_two_power_down &&
        cur.sense_one_threshold_sel == 3'h3 && cur.sense_two_threshold_sel == 3'h3)
        else $error("monitor not disabled after reset");
    a_ch_one_cfg: assert property (@(posedge clock) disable iff (!nrst)
        s_ch_one_write |=> cur.sense_one_power_down == $past(cur.shreg[6]) &&
        cur.sense_one_threshold_sel == $past(cur.shreg[4:2]))
        else $error("channel one control not stored");
    a_ch_two_cfg: assert property (@(posedge clock) disable iff (!nrst)
        s_ch_two_write |=> cur.sense_two_power_down == $past(cur.shreg[6]) &&
        cur.sense_two_threshold_sel == $past(cur.shreg[4:2]))
        else $error("channel two control not stored");
    a_pd_no_irq: assert property (@(posedge clock) disable iff (!nrst)
        s_both_down |=> interrupt_request_n)
        else $error("interrupt while both channels off");
    a_user_gate: assert property (@(posedge clock) disable iff (!nrst)
        wr_en && !user_map |-> cur.sub == bsm_pkg::SUB_MAPSEL)
        else $error("monitor written outside user sub map");

endmodule

`default_nettype wire

// [test/bsm_divider.sv]
`default_nettype none

// ----------------------------------------------------------------
// Connector divider model
// ----------------------------------------------------------------
// Scales the connector voltage down to the sense pin. The pin clips at full
// scale so that a battery-level short never wraps round to a small reading.
module bsm_divider #(
    parameter int SENSE_W = 11,
    parameter int R_TOP = 3,
    parameter int R_BOT = 1
) (
    input wire logic [15:0] connector_mv,
    output logic [SENSE_W-1:0] pin_mv
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] divided;

    always_comb
    begin
        divided = (32'(connector_mv) * 32'(R_BOT)) / 32'(R_TOP + R_BOT);
        pin_mv = (divided > 32'((1 << SENSE_W) - 1)) ? '1 : divided[SENSE_W-1:0];
    end
endmodule

`default_nettype wire

// [test/battery_short_fault_monitor_tb.sv]
`default_nettype none

module battery_short_fault_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Harness
    // ----------------------------------------------------------------
    localparam int PHASE = 5;
    localparam int R_TOP = 3;
    localparam int R_BOT = 1;
    logic clock, nrst, scl, sda_m, alsb, irq_n, sda_out, sda_oe, sda_w, sda_seen, irq_seen, ok;
    logic [6:0] dev;
    logic [7:0] rd, rd2, sub;
    logic [15:0] conn [2];
    logic [10:0] pin_one, pin_two;
    int num_errors = 0;
    int n_tests = 0;
    int thr;

    // Open drain: either party pulling low wins, otherwise the pull-up
    assign sda_w = (sda_m && !(sda_oe && !sda_out)) ? 1'b1 : 1'b0;

    bsm_divider #(.R_TOP(R_TOP), .R_BOT(R_BOT)) bsm_divider_one_inst (.connector_mv(conn[0]), .pin_mv(pin_one));
    bsm_divider #(.R_TOP(R_TOP), .R_BOT(R_BOT)) bsm_divider_two_inst (.connector_mv(conn[1]), .pin_mv(pin_two));

    bsm_monitor bsm_monitor_inst (
        .clock(clock),
        .nrst(nrst),
        .scl(scl),
        .sda_in(sda_w),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .alsb(alsb),
        .short_sense_pin_one(pin_one),
        .short_sense_pin_two(pin_two),
        .interrupt_request_n(irq_n)
    );

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Outputs are sampled mid-cycle so reads never race the register update
    always @(negedge clock)
    begin
        sda_seen <= sda_w;
        irq_seen <= irq_n;
    end

    // About 45k cycles of traffic expected; this leaves wide margin
    initial
    begin
        repeat (60000) @(posedge clock);
        num_errors++;
        final_report;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic set_bus(input logic c, input logic d);
        scl <= c;
        sda_m <= d;
        wait_clk(PHASE);
    endtask

    // Data only moves while the clock is low, never on its falling edge
    task automatic bit_io(input logic b, output logic r);
        set_bus(1'b0, sda_m);
        set_bus(1'b0, b);
        set_bus(1'b1, b);
        r = sda_seen;
    endtask

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = (r === 1'b0);
    endtask

    task automatic start_c;
        set_bus(1'b0, 1'b1);
        set_bus(1'b1, 1'b1);
        set_bus(1'b1, 1'b0);
    endtask

    task automatic stop_c;
        set_bus(1'b0, sda_m);
        set_bus(1'b0, 1'b0);
        set_bus(1'b1, 1'b0);
        set_bus(1'b1, 1'b1);
    endtask

    task automatic reg_wr(input logic [7:0] s, input logic [7:0] d, output logic good);
        logic a0, a1, a2;
        start_c;
        wbyte({dev, 1'b0}, a0);
        wbyte(s, a1);
        wbyte(d, a2);
        stop_c;
        good = a0 && a1 && a2;
    endtask

    // Single-byte read ends with a master NACK
    task automatic reg_rd(input logic [7:0] s, output logic [7:0] d, output logic good);
        logic a0, a1, a2, r;
        start_c;
        wbyte({dev, 1'b0}, a0);
        wbyte(s, a1);
        start_c;
        wbyte({dev, 1'b1}, a2);
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
        stop_c;
        good = a0 && a1 && a2;
    endtask

    // Two-byte bursts: the subaddress steps on after each byte
    task automatic burst_wr(input logic [7:0] s, input logic [7:0] d0, input logic [7:0] d1, output logic good);
        logic a0, a1, a2, a3;
        start_c;
        wbyte({dev, 1'b0}, a0);
        wbyte(s, a1);
        wbyte(d0, a2);
        wbyte(d1, a3);
        stop_c;
        good = a0 && a1 && a2 && a3;
    endtask

    task automatic burst_rd(input logic [7:0] s, output logic [7:0] d0, output logic [7:0] d1, output logic good);
        logic a0, a1, a2, r;
        start_c;
        wbyte({dev, 1'b0}, a0);
        wbyte(s, a1);
        start_c;
        wbyte({dev, 1'b1}, a2);
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d0[i]);
        bit_io(1'b0, r);
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d1[i]);
        bit_io(1'b1, r);
        stop_c;
        good = a0 && a1 && a2;
    endtask

    task automatic wr_chk(input logic [7:0] s, input logic [7:0] d, input logic exp_ok);
        reg_wr(s, d, ok);
        check({7'h00, ok}, {7'h00, exp_ok}, "write acknowledge");
    endtask

    task automatic rd_chk(input logic [7:0] s, input logic [7:0] exp);
        reg_rd(s, rd, ok);
        check({7'h00, ok}, 8'h01, "read acknowledge");
        check(rd, exp, "read data");
    endtask

    task automatic irq_chk(input logic exp);
        check({7'h00, irq_seen}, {7'h00, exp}, "interrupt pin");
    endtask

    function automatic logic [7:0] ctrl(input logic pd, input logic [2:0] sel);
        return {1'b0, pd, 1'b0, sel, 2'b00};
    endfunction

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        nrst = 1'b0;
        scl = 1'b1;
        sda_m = 1'b1;
        alsb = 1'b0;
        dev = bsm_pkg::DEV_ADDR_BASE;
        conn[0] = 16'h0000;
        conn[1] = 16'h0000;
        wait_clk(10);
        nrst <= 1'b1;
        wait_clk(5);
        irq_chk(1'b1);
        conn[0] <= 16'h1F40;
        conn[1] <= 16'h1F40;
        wait_clk(8);
        irq_chk(1'b1);
        rd_chk(bsm_pkg::SUB_CH_ONE, ctrl(1'b1, 3'h3));
        rd_chk(bsm_pkg::SUB_CH_TWO, ctrl(1'b1, 3'h3));
        rd_chk(bsm_pkg::SUB_STATUS, 8'h00);
        rd_chk(bsm_pkg::SUB_MAPSEL, 8'h00);
        $display("test reset_defaults done");

        conn[0] <= 16'h0000;
        conn[1] <= 16'h0000;
        for (int ch = 0; ch < 2; ch++)
        begin
            sub = (ch == 1) ? bsm_pkg::SUB_CH_TWO : bsm_pkg::SUB_CH_ONE;
            for (int sel = 0; sel < 8; sel++)
            begin
                thr = bsm_pkg::THR_BASE_MV + bsm_pkg::THR_STEP_MV * sel;
                wr_chk(sub, ctrl(1'b0, 3'(sel)), 1'b1);
                rd_chk(sub, ctrl(1'b0, 3'(sel)));
                conn[ch] <= 16'(thr * (R_TOP + R_BOT) / R_BOT);
                wait_clk(4);
                irq_chk(1'b1);
                conn[ch] <= 16'((thr + 1) * (R_TOP + R_BOT) / R_BOT);
                wait_clk(4);
                irq_chk(1'b0);
                conn[ch] <= 16'h0000;
                rd_chk(bsm_pkg::SUB_STATUS, (ch == 1) ? 8'h02 : 8'h01);
                wait_clk(4);
                irq_chk(1'b1);
                wr_chk(sub, ctrl(1'b1, 3'h3), 1'b1);
            end
        end
        $display("test threshold_sweep done");

        wr_chk(bsm_pkg::SUB_CH_ONE, ctrl(1'b0, 3'h0), 1'b1);
        wr_chk(bsm_pkg::SUB_CH_TWO, ctrl(1'b0, 3'h0), 1'b1);
        conn[0] <= 16'h07D0;
        conn[1] <= 16'h07D0;
        wait_clk(4);
        conn[0] <= 16'h0000;
        conn[1] <= 16'h0000;
        wait_clk(20);
        irq_chk(1'b0);
        rd_chk(bsm_pkg::SUB_STATUS, 8'h03);
        rd_chk(bsm_pkg::SUB_STATUS, 8'h00);
        conn[0] <= 16'h07D0;
        wait_clk(4);
        conn[0] <= 16'h0000;
        irq_chk(1'b0);
        wr_chk(bsm_pkg::SUB_CH_ONE, ctrl(1'b1, 3'h0), 1'b1);
        wait_clk(4);
        irq_chk(1'b1);
        rd_chk(bsm_pkg::SUB_STATUS, 8'h00);
        $display("test latch_and_power_down done");

        // Refused accesses must leave the control registers untouched
        wr_chk(bsm_pkg::SUB_STATUS, 8'hFF, 1'b0);
        wr_chk(bsm_pkg::SUB_MAPSEL, 8'h20, 1'b1);
        wr_chk(bsm_pkg::SUB_CH_ONE, ctrl(1'b0, 3'h5), 1'b0);
        rd_chk(bsm_pkg::SUB_MAPSEL, 8'h20);
        wr_chk(bsm_pkg::SUB_MAPSEL, 8'h00, 1'b1);
        rd_chk(bsm_pkg::SUB_CH_ONE, ctrl(1'b1, 3'h0));
        alsb <= 1'b1;
        wait_clk(4);
        wr_chk(bsm_pkg::SUB_CH_ONE, ctrl(1'b1, 3'h7), 1'b0);
        dev = bsm_pkg::DEV_ADDR_BASE | 7'(1 << bsm_pkg::ADDR_SEL_BIT);
        wr_chk(bsm_pkg::SUB_CH_ONE, ctrl(1'b1, 3'h7), 1'b1);
        rd_chk(bsm_pkg::SUB_CH_ONE, ctrl(1'b1, 3'h7));
        $display("test refusals done");

        burst_wr(bsm_pkg::SUB_CH_ONE, ctrl(1'b1, 3'h1), ctrl(1'b1, 3'h6), ok);
        check({7'h00, ok}, 8'h01, "burst write acknowledge");
        burst_rd(bsm_pkg::SUB_CH_ONE, rd, rd2, ok);
        check({7'h00, ok}, 8'h01, "burst read acknowledge");
        check(rd, ctrl(1'b1, 3'h1), "burst first byte");
        check(rd2, ctrl(1'b1, 3'h6), "burst second byte");
        $display("test bursts done");
        final_report;
    end
endmodule

`default_nettype wire
